/* File: uic_pkg.sv */
package uic_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int OVERSAMPLE = 16;
  localparam int TO_CHARS = 4;
  localparam int TO_EXTRA_BITS = 12;
  localparam int TO_BITS_W = 7;
  // Start bit, five data bits and one stop bit
  localparam logic [6:0] CHAR_BASE_BITS = 7'h07;

  // ----------------------------------------------------------------
  // Register offsets on the three address lines
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_MASK = 3'h1;
  localparam logic [2:0] OFF_SRC = 3'h2;
  localparam logic [2:0] OFF_FMT = 3'h3;
  localparam logic [2:0] OFF_LSR = 3'h5;
  localparam logic [2:0] OFF_MSR = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FMT_DLAB = 7;
  localparam int FMT_PAR_EN = 3;
  localparam int FMT_STOP = 2;
  localparam int FCR_EN = 0;
  localparam int FCR_RX_RST = 1;
  localparam int FCR_TX_RST = 2;
  localparam int FCR_DMA = 3;
  localparam int FCR_TRIG = 6;
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LINE = 2;
  localparam int MASK_MODEM = 3;
  // Receive entry: data, then parity, framing and break tags
  localparam int RXE_PAR = 8;
  localparam int RX_W = 11;

  // ----------------------------------------------------------------
  // Interrupt source codes and trigger levels
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_LINE = 4'h6;
  localparam logic [3:0] SRC_TIMEOUT = 4'hc;
  localparam logic [3:0] SRC_RX = 4'h4;
  localparam logic [3:0] SRC_TX = 4'h2;
  localparam logic [3:0] SRC_MODEM = 4'h0;
  localparam logic [3:0] SRC_NONE = 4'h1;
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [15:0] DIV_ONE = 16'h0001;
  localparam logic [15:0] DIV_RST = DIV_ONE;

endpackage : uic_pkg

/* File: uic_fifo.sv */
`timescale 1ns/1ps
module uic_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  input wire logic i_pop,
  // State
  output logic [W-1:0] o_head,
  output logic [CW-1:0] o_count
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire logic do_push = i_push && (cnt_q != CW'(DEPTH));
  wire logic do_pop = i_pop && (cnt_q != '0);

  always_ff @(posedge i_clk) begin
    if (do_push) mem_q[wr_q] <= i_data;
  end

  // Flush touches pointers and level only, never the stored words
  always_ff @(posedge i_clk) begin
    if (i_rst || i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop) rd_q <= rd_q + 1'b1;
      if (do_push && !do_pop) cnt_q <= cnt_q + 1'b1;
      else if (do_pop && !do_push) cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_head = mem_q[rd_q];
  assign o_count = cnt_q;

endmodule : uic_fifo

/* File: uic_rx_timeout.sv */
`timescale 1ns/1ps
module uic_rx_timeout #(
  parameter int OS = 16,
  parameter int BW = 7
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic [BW-1:0] i_limit,
  // Expiry pulse
  output logic o_fire
);
  localparam int SW = $clog2(OS);
  localparam logic [SW-1:0] SUB_MAX = SW'(OS - 1);

  logic [SW-1:0] sub_q;
  logic [BW-1:0] bits_q;
  logic done_q;
  logic fire_q;
  wire logic bit_end = i_tick && !done_q && (sub_q == SUB_MAX);
  wire logic at_limit = bit_end && (bits_q + 1'b1 == i_limit);

  // Fires once per idle gap; needs a restart or a low i_run to arm again
  always_ff @(posedge i_clk) begin
    if (i_rst || i_restart || !i_run) begin
      sub_q <= '0;
      bits_q <= '0;
      done_q <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      if (i_tick && !done_q) sub_q <= sub_q + 1'b1;
      if (bit_end) bits_q <= bits_q + 1'b1;
      if (at_limit) done_q <= 1'b1;
      fire_q <= at_limit;
    end
  end

  assign o_fire = fire_q;

endmodule : uic_rx_timeout

/* File: uic_top.sv */
`timescale 1ns/1ps
module uic_top #(
  parameter int DEPTH = uic_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Host register port
  input wire logic [2:0] I_ADDR,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  // Receive shifter
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_PAR_ERR,
  input wire logic I_RX_FRM_ERR,
  input wire logic I_RX_BREAK,
  // Transmit shifter
  output logic O_TX_VALID,
  output logic [7:0] O_TX_DATA,
  input wire logic I_TX_TAKE,
  input wire logic I_TX_SHIFT_BUSY,
  // Modem status
  input wire logic [3:0] I_MODEM_DELTA,
  input wire logic [3:0] I_MODEM_LINES,
  output logic O_MODEM_STATUS_READ,
  // Line side controls
  output logic O_BAUD_TICK,
  output logic [7:0] O_LINE_FORMAT,
  // Interrupt and DMA requests
  output logic O_INT,
  output logic O_TX_DMA_REQUEST_N,
  output logic O_RX_DMA_REQUEST_N
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int RW = uic_pkg::RX_W;
  localparam int PE = uic_pkg::RXE_PAR;

  logic [7:0] fmt_q;
  logic [15:0] div_q;
  logic [15:0] baud_cnt_q;
  logic baud_tick_q;
  logic [3:0] mask_q;
  logic fifo_en_q;
  logic dma_q;
  logic [1:0] trig_q;
  logic [CW-1:0] trig_lvl;
  logic oe_q;
  logic [2:0] err_q;
  logic [CW-1:0] err_cnt_q;
  logic thr_int_q;
  logic tx_empty_q;
  logic to_int_q;
  logic [3:0] isr_code;
  logic [7:0] rd_val;
  logic [7:0] rdata_q;
  logic [RW-1:0] rx_head;
  logic [CW-1:0] rx_cnt;
  logic [7:0] tx_head;
  logic [CW-1:0] tx_cnt;
  logic to_fire;
  logic [7:0] line_status;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic dlab = fmt_q[uic_pkg::FMT_DLAB];
  wire logic a_data = I_ADDR == uic_pkg::OFF_DATA;
  wire logic a_mask = I_ADDR == uic_pkg::OFF_MASK;
  wire logic a_src = I_ADDR == uic_pkg::OFF_SRC;
  wire logic wr_data = I_WR && a_data && !dlab;
  wire logic rd_data = I_RD && a_data && !dlab;
  wire logic wr_dll = I_WR && a_data && dlab;
  wire logic wr_dlm = I_WR && a_mask && dlab;
  wire logic wr_mask = I_WR && a_mask && !dlab;
  wire logic wr_fcr = I_WR && a_src && !dlab;
  wire logic rd_isr = I_RD && a_src && !dlab;
  wire logic wr_fmt = I_WR && (I_ADDR == uic_pkg::OFF_FMT);
  wire logic rd_lsr = I_RD && (I_ADDR == uic_pkg::OFF_LSR);
  wire logic rd_msr = I_RD && (I_ADDR == uic_pkg::OFF_MSR);

  // ----------------------------------------------------------------
  // Line format, divisor and baud counter
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) fmt_q <= uic_pkg::FMT_RST;
    else if (wr_fmt) fmt_q <= I_WDATA;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      div_q <= uic_pkg::DIV_RST;
    end else begin
      if (wr_dll) div_q[7:0] <= I_WDATA;
      if (wr_dlm) div_q[15:8] <= I_WDATA;
    end
  end

  // A zero divisor parks the counter rather than dividing by 65536
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || div_q == '0) begin
      baud_cnt_q <= '0;
      baud_tick_q <= 1'b0;
    end else if (baud_cnt_q <= uic_pkg::DIV_ONE) begin
      baud_cnt_q <= div_q;
      baud_tick_q <= 1'b1;
    end else begin
      baud_cnt_q <= baud_cnt_q - 1'b1;
      baud_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask and FIFO setup
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) mask_q <= uic_pkg::MASK_RST;
    else if (wr_mask) mask_q <= I_WDATA[3:0];
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      fifo_en_q <= uic_pkg::FCR_RST[uic_pkg::FCR_EN];
      dma_q <= uic_pkg::FCR_RST[uic_pkg::FCR_DMA];
      trig_q <= uic_pkg::FCR_RST[uic_pkg::FCR_TRIG +: 2];
    end else if (wr_fcr) begin
      fifo_en_q <= I_WDATA[uic_pkg::FCR_EN];
      if (I_WDATA[uic_pkg::FCR_EN]) begin
        dma_q <= I_WDATA[uic_pkg::FCR_DMA];
        trig_q <= I_WDATA[uic_pkg::FCR_TRIG +: 2];
      end
    end
  end

  // Switching FIFO mode flushes both queues so no stale level survives
  wire logic fcr_on = wr_fcr && I_WDATA[uic_pkg::FCR_EN];
  wire logic en_change = wr_fcr && (I_WDATA[uic_pkg::FCR_EN] != fifo_en_q);
  wire logic rx_flush = en_change
    || (fcr_on && I_WDATA[uic_pkg::FCR_RX_RST]);
  wire logic tx_flush = en_change
    || (fcr_on && I_WDATA[uic_pkg::FCR_TX_RST]);

  always_comb begin
    case (trig_q)
      2'h0: trig_lvl = CW'(uic_pkg::TRIG_1);
      2'h1: trig_lvl = CW'(uic_pkg::TRIG_4);
      2'h2: trig_lvl = CW'(uic_pkg::TRIG_8);
      default: trig_lvl = CW'(uic_pkg::TRIG_14);
    endcase
    if (!fifo_en_q) trig_lvl = CW'(uic_pkg::TRIG_1);
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  // Outside FIFO mode the queue holds a single character
  wire logic rx_has = rx_cnt != '0;
  wire logic rx_full = fifo_en_q ? (rx_cnt == CW'(DEPTH)) : rx_has;
  wire logic rx_push = I_RX_VALID && !rx_full;
  wire logic rx_over = I_RX_VALID && rx_full;
  wire logic rx_pop = rd_data && rx_has;
  wire logic rx_hit = rx_cnt >= trig_lvl;
  wire logic [2:0] in_err = {I_RX_BREAK, I_RX_FRM_ERR, I_RX_PAR_ERR};
  wire logic push_err = rx_push && (in_err != '0);
  wire logic pop_err = rx_pop && (rx_head[PE +: 3] != '0);

  uic_fifo #(
    .W(RW),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_rx_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SRST),
    .i_flush(rx_flush),
    .i_push(rx_push),
    .i_data({in_err, I_RX_DATA}),
    .i_pop(rx_pop),
    .o_head(rx_head),
    .o_count(rx_cnt)
  );

  // Count of tagged entries so the global error flag needs no scan
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || rx_flush) err_cnt_q <= '0;
    else if (push_err && !pop_err) err_cnt_q <= err_cnt_q + 1'b1;
    else if (pop_err && !push_err) err_cnt_q <= err_cnt_q - 1'b1;
  end

  // Sticky line errors; a new event in the clearing cycle is kept
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      oe_q <= 1'b0;
      err_q <= '0;
    end else begin
      if (rx_over) oe_q <= 1'b1;
      else if (rd_lsr) oe_q <= 1'b0;
      if (pop_err) err_q <= err_q | rx_head[PE +: 3];
      else if (rd_lsr) err_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Receive time-out
  // ----------------------------------------------------------------
  wire logic [6:0] char_bits = uic_pkg::CHAR_BASE_BITS + 7'(fmt_q[1:0])
    + 7'(fmt_q[uic_pkg::FMT_PAR_EN]) + 7'(fmt_q[uic_pkg::FMT_STOP]);
  wire logic [6:0] to_bits = 7'(uic_pkg::TO_CHARS * char_bits
    + uic_pkg::TO_EXTRA_BITS);

  uic_rx_timeout #(
    .OS(uic_pkg::OVERSAMPLE),
    .BW(uic_pkg::TO_BITS_W)
  ) u_rx_timeout (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SRST),
    .i_tick(baud_tick_q),
    .i_run(fifo_en_q && rx_has),
    .i_restart(rx_push || rx_pop),
    .i_limit(to_bits),
    .o_fire(to_fire)
  );

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) to_int_q <= 1'b0;
    else if (to_fire) to_int_q <= 1'b1;
    else if (rd_data) to_int_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  wire logic tx_empty = tx_cnt == '0;
  wire logic tx_full = fifo_en_q ? (tx_cnt == CW'(DEPTH)) : !tx_empty;

  uic_fifo #(
    .W(8),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_tx_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SRST),
    .i_flush(tx_flush),
    .i_push(wr_data && !tx_full),
    .i_data(I_WDATA),
    .i_pop(I_TX_TAKE),
    .o_head(tx_head),
    .o_count(tx_cnt)
  );

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) tx_empty_q <= 1'b1;
    else tx_empty_q <= tx_empty;
  end

  // Enabling the mask while already empty also arms the interrupt
  wire logic thr_set = (tx_empty && !tx_empty_q)
    || (wr_mask && I_WDATA[uic_pkg::MASK_TX]
        && !mask_q[uic_pkg::MASK_TX] && tx_empty);
  wire logic thr_clr = wr_data
    || (rd_isr && isr_code == uic_pkg::SRC_TX);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) thr_int_q <= 1'b0;
    else if (thr_set) thr_int_q <= 1'b1;
    else if (thr_clr) thr_int_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupt priority
  // ----------------------------------------------------------------
  wire logic line_pend = mask_q[uic_pkg::MASK_LINE] && (oe_q || err_q != '0);
  wire logic to_pend = mask_q[uic_pkg::MASK_RX] && to_int_q;
  wire logic rx_pend = mask_q[uic_pkg::MASK_RX] && rx_hit;
  wire logic tx_pend = mask_q[uic_pkg::MASK_TX] && thr_int_q;
  wire logic ms_pend = mask_q[uic_pkg::MASK_MODEM]
    && (I_MODEM_DELTA != '0);

  always_comb begin
    if (line_pend) isr_code = uic_pkg::SRC_LINE;
    else if (to_pend) isr_code = uic_pkg::SRC_TIMEOUT;
    else if (rx_pend) isr_code = uic_pkg::SRC_RX;
    else if (tx_pend) isr_code = uic_pkg::SRC_TX;
    else if (ms_pend) isr_code = uic_pkg::SRC_MODEM;
    else isr_code = uic_pkg::SRC_NONE;
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  wire logic [2:0] head_err = rx_has ? rx_head[PE +: 3] : '0;
  assign line_status = {err_cnt_q != '0, tx_empty && !I_TX_SHIFT_BUSY, tx_empty,
    err_q | head_err, oe_q, rx_has};

  always_comb begin
    rd_val = '0;
    case (I_ADDR)
      uic_pkg::OFF_DATA: rd_val = dlab ? div_q[7:0] : rx_head[PE-1:0];
      uic_pkg::OFF_MASK: rd_val = dlab ? div_q[15:8] : {4'h0, mask_q};
      uic_pkg::OFF_SRC: rd_val = dlab ? 8'h00
        : {{2{fifo_en_q}}, 2'h0, isr_code};
      uic_pkg::OFF_FMT: rd_val = fmt_q;
      uic_pkg::OFF_LSR: rd_val = line_status;
      uic_pkg::OFF_MSR: rd_val = {I_MODEM_LINES, I_MODEM_DELTA};
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) rdata_q <= '0;
    else if (I_RD) rdata_q <= rd_val;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_RDATA = rdata_q;
  assign O_TX_VALID = !tx_empty;
  assign O_TX_DATA = tx_head;
  assign O_MODEM_STATUS_READ = rd_msr;
  assign O_BAUD_TICK = baud_tick_q;
  assign O_LINE_FORMAT = fmt_q;
  assign O_INT = isr_code != uic_pkg::SRC_NONE;
  assign O_RX_DMA_REQUEST_N = dma_q ? !(rx_hit || to_int_q)
    : !rx_has;
  assign O_TX_DMA_REQUEST_N = dma_q ? tx_full : !tx_empty;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  property p_idle_code;
    rd_isr |=> O_RDATA[0] == !$past(O_INT);
  endproperty
  a_idle_code: assert property (p_idle_code)
    else $error("idle source code wrong");

  property p_line_first;
    line_pend |-> isr_code == uic_pkg::SRC_LINE;
  endproperty
  a_line_first: assert property (p_line_first)
    else $error("line status not top priority");

  property p_rx_trig;
    fifo_en_q && mask_q[0] && rx_cnt >= trig_lvl && !line_pend && !to_pend
      |-> isr_code == uic_pkg::SRC_RX && O_INT;
  endproperty
  a_rx_trig: assert property (p_rx_trig)
    else $error("receive trigger interrupt missing");

  property p_thr_clear;
    wr_data && !thr_set |=> !thr_int_q;
  endproperty
  a_thr_clear: assert property (p_thr_clear)
    else $error("transmit ready not cleared by write");

  property p_to_clear;
    rd_data && !to_fire |=> !to_int_q;
  endproperty
  a_to_clear: assert property (p_to_clear)
    else $error("time-out not cleared by read");

  property p_div_locked;
    !dlab |=> $stable(div_q);
  endproperty
  a_div_locked: assert property (p_div_locked)
    else $error("divisor changed while locked");

  property p_ready_set;
    rx_cnt == '0 && rx_push && !rx_flush |=> line_status[0];
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("data ready did not set");

  property p_src_fifo_bits;
    rd_isr |=> O_RDATA[7:6] == {2{$past(fifo_en_q)}};
  endproperty
  a_src_fifo_bits: assert property (p_src_fifo_bits)
    else $error("fifo enable bits wrong");

  property p_fcr_gate;
    wr_fcr && !I_WDATA[0] |=> !fifo_en_q && $stable(trig_q) && $stable(dma_q);
  endproperty
  a_fcr_gate: assert property (p_fcr_gate)
    else $error("setup bits programmed without enable");

  property p_rx_flush;
    wr_fcr && I_WDATA[0] && I_WDATA[1] ##1 !wr_fcr
      |-> rx_cnt == '0 && !rx_flush;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("receive flush failed");

  property p_overrun;
    mask_q[2] && rx_over && !wr_mask |=> O_INT
      && isr_code == uic_pkg::SRC_LINE;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun did not interrupt");

  property p_trig14;
    fifo_en_q && trig_q == 2'h3 |-> trig_lvl == CW'(uic_pkg::TRIG_14);
  endproperty
  a_trig14: assert property (p_trig14)
    else $error("trigger fourteen wrong");

  c_timeout: cover property (to_fire ##[1:40] rd_data);
  c_full: cover property (fifo_en_q && rx_cnt == CW'(DEPTH));
  c_tx_int: cover property (tx_pend ##1 rd_isr);
  c_overrun: cover property (rx_over ##[1:20] rd_lsr);

endmodule : uic_top

/* File: uic_line_model.sv */
`timescale 1ns/1ps
module uic_line_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Receive side
  input wire logic i_send,
  input wire logic [7:0] i_char,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  // Transmit side
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_take,
  output logic o_busy,
  output logic [7:0] o_last_tx
);
  // ------------------------------------------------------------
  // Shifter stand-ins
  // ------------------------------------------------------------
  logic [3:0] cnt_q;
  assign o_busy = (cnt_q != 4'h0);
  always_ff @(posedge i_clk) begin
    o_rx_valid <= i_send;
    // Idle data lines toggle so stale bytes are never mistaken for new
    o_rx_data <= i_send ? i_char : ~o_rx_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
      o_tx_take <= 1'b0;
      o_last_tx <= 8'h00;
    end else if (i_tx_valid && !o_tx_take && cnt_q == 4'h0) begin
      o_tx_take <= 1'b1;
      o_last_tx <= i_tx_data;
      cnt_q <= 4'h8;
    end else begin
      o_tx_take <= 1'b0;
      if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : uic_line_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic send = 1'b0;
  logic [7:0] sch = 8'h00;
  logic rxv, txv, take, busy, irq;
  logic [7:0] rxd, txd, last;
  logic tick, msr_rd, txq_n, rxq_n;
  logic [7:0] fmt;
  logic [3:0] mset = 4'h0;
  logic [3:0] mdelta = 4'h0;
  int failures = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  uic_top i_dut (
    .I_CORE_CLK(clk), .I_SRST(rst), .I_ADDR(addr), .I_WR(wr),
    .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .I_RX_VALID(rxv),
    .I_RX_DATA(rxd), .I_RX_PAR_ERR(1'b0), .I_RX_FRM_ERR(1'b0),
    .I_RX_BREAK(1'b0), .O_TX_VALID(txv), .O_TX_DATA(txd),
    .I_TX_TAKE(take), .I_TX_SHIFT_BUSY(busy), .I_MODEM_DELTA(mdelta),
    .I_MODEM_LINES(4'h0), .O_MODEM_STATUS_READ(msr_rd),
    .O_BAUD_TICK(tick), .O_LINE_FORMAT(fmt), .O_INT(irq),
    .O_TX_DMA_REQUEST_N(txq_n), .O_RX_DMA_REQUEST_N(rxq_n)
  );
  // Modem deltas live outside the block and clear on a status read
  always @(posedge clk) mdelta <= msr_rd ? 4'h0 : (mdelta | mset);
  uic_line_model i_line (
    .i_clk(clk), .i_rst(rst), .i_send(send), .i_char(sch),
    .o_rx_valid(rxv), .o_rx_data(rxd), .i_tx_valid(txv),
    .i_tx_data(txd), .o_tx_take(take), .o_busy(busy),
    .o_last_tx(last)
  );
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wreg(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // Reads pop or clear, so each one is a single strobe
  task automatic rreg(logic [2:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg%0d", a), rdata, exp);
  endtask : rreg
  task automatic rxc(logic [7:0] d);
    @(posedge clk);
    send <= 1'b1;
    sch <= d;
    @(posedge clk);
    send <= 1'b0;
  endtask : rxc
  task automatic close_out;
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rreg(3'h2, 8'h01);
    chk("tick", {7'h00, tick}, 8'h01);
    rreg(3'h1, 8'h00);
    rreg(3'h5, 8'h60);
    wreg(3'h2, 8'h41);
    rreg(3'h2, 8'hc1);
    wreg(3'h1, 8'h01);
    for (int i = 0; i < 3; i++) rxc(8'h20 + 8'(i));
    rreg(3'h2, 8'hc1);
    rreg(3'h5, 8'h61);
    rxc(8'h23);
    rreg(3'h2, 8'hc4);
    chk("int", {7'h00, irq}, 8'h01);
    rreg(3'h0, 8'h20);
    rreg(3'h2, 8'hc1);
    wreg(3'h2, 8'h43);
    rreg(3'h5, 8'h60);
    wreg(3'h1, 8'h03);
    rreg(3'h2, 8'hc2);
    rreg(3'h2, 8'hc1);
    wreg(3'h0, 8'h5a);
    repeat (4) @(posedge clk);
    rreg(3'h2, 8'hc2);
    chk("tx", last, 8'h5a);
    // Seventeen characters into sixteen places forces an overrun
    wreg(3'h1, 8'h05);
    for (int i = 0; i < 17; i++) rxc(8'h10 + 8'(i));
    rreg(3'h2, 8'hc6);
    rreg(3'h5, 8'h63);
    rreg(3'h2, 8'hc4);
    repeat (660) @(posedge clk);
    rreg(3'h2, 8'hcc);
    rreg(3'h0, 8'h10);
    rreg(3'h2, 8'hc4);
    wreg(3'h3, 8'h80);
    wreg(3'h0, 8'h34);
    wreg(3'h1, 8'h12);
    rreg(3'h0, 8'h34);
    rreg(3'h1, 8'h12);
    wreg(3'h3, 8'h03);
    rreg(3'h1, 8'h05);
    rreg(3'h3, 8'h03);
    chk("fmt", fmt, 8'h03);
    // Modem source alone, lowest priority code
    wreg(3'h1, 8'h08);
    @(posedge clk);
    mset <= 4'h2;
    @(posedge clk);
    mset <= 4'h0;
    rreg(3'h2, 8'hc0);
    chk("int", {7'h00, irq}, 8'h01);
    rreg(3'h6, 8'h02);
    rreg(3'h2, 8'hc1);
    // DMA mode with trigger fourteen: request follows the trigger
    wreg(3'h2, 8'hc9);
    chk("rxq", {7'h00, rxq_n}, 8'h00);
    chk("txq", {7'h00, txq_n}, 8'h00);
    rreg(3'h0, 8'h11);
    rreg(3'h0, 8'h12);
    chk("rxq", {7'h00, rxq_n}, 8'h01);
    close_out;
  end
endmodule : tb
